/* File: rtl/slc_stack_status.sv */
// Purpose: Stack limit checking, stack error trap and CPU status word access
// Assumes: Core logic on core_clk drives stack accesses and engine flags
// Notes: Registers reached over APB; core writes to status word come via alu port
//
// Chosen here: the APB interface to the registers and the placing of the registers.

// Notes on behaviour
// RULE1 - Stack limit is 16 bits with bit 0 always zero.
// RULE2 - Overflow checking enabled only by a word write to the stack limit.
// RULE3 - Once enabled, checking stays on until device reset.
// RULE4 - Every stack pointer effective address compared against limit while enabled; here only push addresses are compared.
// RULE5 - Push with pointer above limit by two traps on that push.
// RULE6 - Calls and interrupt stacking are checked the same way.
// RULE7 - Wrap past end of data space traps while checking enabled.
// RULE8 - Software avoids indirect stack read right after a limit write.
// RULE9 - Stack pointer resets to 0x0800; below 0x0800 raises a trap.
// RULE10 - Status word is 16 bits with low and high bytes.
// RULE11 - Exception stacking word is status low byte joined with PC top byte.
// RULE12 - Loop active flag at bit 9 is read only.
// RULE13 - Repeat active flag at bit 4 is read only.
// RULE14 - Overflow flags are read only, updated by the engine.
// RULE15 - Saturation flags are sticky, set by engine, cleared by software.
// RULE16 - Clearing combined saturation clears both accumulator saturation flags.
// RULE17 - Digit carry at bit 8 and arithmetic flags are writable.
// RULE18 - Remaining status bits are read and write.
// RULE19 - Priority level is top bit joined with status bits 7 to 5.
// RULE20 - Stack pointer bit 0 is forced to zero.
// RULE21 - Priority bits read only while nesting disable is set.
// RULE22 - User interrupts blocked while the top priority bit is one.
// RULE23 - Each trap is a one cycle pulse with an overflow or underflow cause.
module slc_stack_status (
   input wire logic core_clk, // Core clock
   input wire logic rst, // Async reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire slc_pkg::slc_stack_access_t stack_acc, // Stack pointer access
   input wire logic sp_load, // Core loads new stack pointer
   input wire logic [15:0] sp_load_val, // New stack pointer value
   input wire slc_pkg::slc_engine_flags_t eng_flags, // Engine and loop flags
   input wire logic alu_wr, // Core writes arithmetic flags
   input wire logic [4:0] alu_flags, // Digit carry, N, OV, Z, C
   input wire logic priority_level_top, // Top priority bit from core control
   input wire logic nesting_disable, // Nesting disable control
   input wire logic [7:0] pc_top_byte, // Program counter top byte
   output slc_pkg::slc_trap_t stack_trap, // Stack error trap
   output logic [3:0] cpu_priority, // Combined priority level
   output logic user_irq_block, // User interrupts blocked
   output logic [15:0] exc_stack_word, // Word stacked on exception
   output logic [15:0] stack_pointer_reg // Current stack pointer
);
   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic acc_phase;
   logic wr_en;
   logic word_wr;
   logic low_wr;
   logic high_wr;
   logic addr_ok;
   logic [15:0] wdata16;
   assign acc_phase = psel && penable;
   assign wr_en = acc_phase && pwrite;
   assign word_wr = pstrb[0] && pstrb[1];
   assign low_wr = pstrb[0];
   assign high_wr = pstrb[1];
   assign wdata16 = pwdata[15:0];
   assign addr_ok = (paddr == slc_pkg::OFS_STACK_LIMIT) || (paddr == slc_pkg::OFS_STATUS_WORD)
      || (paddr == slc_pkg::OFS_STACK_PTR) || (paddr == slc_pkg::OFS_CONTROL)
      || (paddr == slc_pkg::OFS_TRAP_INFO);

   // ------------------------------------------------------------
   // Stack limit and enable
   // ------------------------------------------------------------
   logic [15:0] stack_limit_reg;
   logic check_en_reg;
   logic limit_wr;
   assign limit_wr = wr_en && (paddr == slc_pkg::OFS_STACK_LIMIT);

   // RULE1 word aligned limit
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         stack_limit_reg <= slc_pkg::STACK_LIMIT_RESET;
      else if (limit_wr)
      begin
         if (low_wr)
            stack_limit_reg[7:0] <= {wdata16[7:1], 1'b0};
         if (high_wr)
            stack_limit_reg[15:8] <= wdata16[15:8];
      end
   end

   // RULE2 RULE3 enable latches on word write
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         check_en_reg <= 1'b0;
      else if (limit_wr && word_wr)
         check_en_reg <= 1'b1;
   end

   // ------------------------------------------------------------
   // Stack pointer
   // ------------------------------------------------------------
   logic sp_bus_wr;
   logic [15:0] sp_next;
   assign sp_bus_wr = wr_en && (paddr == slc_pkg::OFS_STACK_PTR) && word_wr;
   always_comb
   begin
      sp_next = stack_pointer_reg;
      if (sp_bus_wr)
         sp_next = wdata16;
      else if (sp_load)
         sp_next = sp_load_val;
      else if (stack_acc.valid && stack_acc.is_push)
         sp_next = stack_pointer_reg + slc_pkg::STACK_STEP;
      else if (stack_acc.valid && stack_acc.is_pop)
         sp_next = stack_pointer_reg - slc_pkg::STACK_STEP;
   end

   // RULE9 RULE20 reset value and bit 0 cleared
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         stack_pointer_reg <= slc_pkg::STACK_PTR_RESET;
      else
         stack_pointer_reg <= {sp_next[15:1], 1'b0};
   end

   // ------------------------------------------------------------
   // Stack checks
   // ------------------------------------------------------------
   logic ovf_hit;
   logic wrap_hit;
   logic unf_hit;
   logic [16:0] ea_sum;
   assign ea_sum = {1'b0, stack_acc.ea} + {1'b0, slc_pkg::STACK_STEP};
   // RULE4 RULE5 RULE6 compare every push address against the limit
   assign ovf_hit = check_en_reg && stack_acc.valid && stack_acc.is_push
      && (stack_acc.ea > stack_limit_reg);
   // RULE7 wrap at end of data space
   assign wrap_hit = check_en_reg && stack_acc.valid && stack_acc.is_push && ea_sum[16];
   // RULE9 floor check
   assign unf_hit = stack_acc.valid && (stack_acc.ea < slc_pkg::STACK_FLOOR);

   // RULE23 one cycle trap pulse
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         stack_trap <= '0;
      else
      begin
         stack_trap.pulse <= ovf_hit || wrap_hit || unf_hit;
         stack_trap.underflow <= unf_hit && !(ovf_hit || wrap_hit);
      end
   end

   // ------------------------------------------------------------
   // Status word
   // ------------------------------------------------------------
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic sr_wr;
   logic [15:0] sr_bmask;
   logic [15:0] sr_wmask;
   assign sr_wr = wr_en && (paddr == slc_pkg::OFS_STATUS_WORD);
   assign sr_bmask = {{8{high_wr}}, {8{low_wr}}};

   always_comb
   begin
      sr_wmask = slc_pkg::SW_WRITE_MASK & sr_bmask;
      // RULE21 priority bits locked
      if (nesting_disable)
         sr_wmask = sr_wmask & ~slc_pkg::PRIO_MASK;
      status_next = status_reg;
      // RULE17 RULE18 writable bits
      if (sr_wr)
         status_next = (status_reg & ~sr_wmask) | (wdata16 & sr_wmask);
      else if (alu_wr)
         status_next[slc_pkg::BIT_DIGIT_CARRY] = alu_flags[4];
      if (alu_wr && !sr_wr)
         status_next[3:0] = alu_flags[3:0];
      // RULE15 RULE16 software clears sticky flags
      if (sr_wr && high_wr && !wdata16[slc_pkg::BIT_COMB_SAT])
      begin
         status_next[slc_pkg::BIT_ACC_A_SAT] = 1'b0;
         status_next[slc_pkg::BIT_ACC_B_SAT] = 1'b0;
      end
      if (sr_wr && high_wr && !wdata16[slc_pkg::BIT_ACC_A_SAT])
         status_next[slc_pkg::BIT_ACC_A_SAT] = 1'b0;
      if (sr_wr && high_wr && !wdata16[slc_pkg::BIT_ACC_B_SAT])
         status_next[slc_pkg::BIT_ACC_B_SAT] = 1'b0;
      // RULE15 engine set wins over clear
      if (eng_flags.acc_a_sat)
         status_next[slc_pkg::BIT_ACC_A_SAT] = 1'b1;
      if (eng_flags.acc_b_sat)
         status_next[slc_pkg::BIT_ACC_B_SAT] = 1'b1;
      status_next[slc_pkg::BIT_COMB_SAT] = status_next[slc_pkg::BIT_ACC_A_SAT]
         | status_next[slc_pkg::BIT_ACC_B_SAT];
      // RULE14 overflow flags from engine only
      status_next[slc_pkg::BIT_ACC_A_OVF] = eng_flags.acc_a_ovf;
      status_next[slc_pkg::BIT_ACC_B_OVF] = eng_flags.acc_b_ovf;
      status_next[slc_pkg::BIT_COMB_OVF] = eng_flags.acc_a_ovf | eng_flags.acc_b_ovf;
      // RULE12 RULE13 read only activity flags
      status_next[slc_pkg::BIT_LOOP_ACT] = eng_flags.loop_active;
      status_next[slc_pkg::BIT_REPEAT_ACT] = eng_flags.repeat_active;
   end

   // RULE10 sixteen bit status word
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         status_reg <= slc_pkg::STATUS_RESET;
      else
         status_reg <= status_next;
   end

   // ------------------------------------------------------------
   // Priority and exception word
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cpu_priority <= 4'h0;
         user_irq_block <= 1'b0;
         exc_stack_word <= 16'h0000;
      end
      else
      begin
         // RULE19 combined priority level
         cpu_priority <= {priority_level_top, status_next[slc_pkg::BIT_PRIO_HI:slc_pkg::BIT_PRIO_LO]};
         // RULE22 top bit blocks user interrupts
         user_irq_block <= priority_level_top;
         // RULE11 low byte with program counter top byte
         exc_stack_word <= {pc_top_byte, status_next[7:0]};
      end
   end

   // ------------------------------------------------------------
   // APB read path
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         slc_pkg::OFS_STACK_LIMIT: rd_mux = {16'h0000, stack_limit_reg};
         slc_pkg::OFS_STATUS_WORD: rd_mux = {16'h0000, status_reg};
         slc_pkg::OFS_STACK_PTR: rd_mux = {16'h0000, stack_pointer_reg};
         slc_pkg::OFS_CONTROL: rd_mux = {31'h0000_0000, check_en_reg};
         slc_pkg::OFS_TRAP_INFO: rd_mux = {28'h000_0000, cpu_priority};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Zero wait state slave: ready follows the setup cycle
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_limit_aligned: assert property ( // RULE1
      @(posedge core_clk) disable iff (rst)
      !stack_limit_reg[0])
      else $error("limit bit 0 set");
   a_byte_no_enable: assert property ( // RULE2
      @(posedge core_clk) disable iff (rst)
      (!check_en_reg && limit_wr && !word_wr) |=> !check_en_reg)
      else $error("byte write enabled check");
   a_enable_sticky: assert property ( // RULE3
      @(posedge core_clk) disable iff (rst)
      check_en_reg |=> check_en_reg)
      else $error("check disabled");
   a_overflow_trap: assert property ( // RULE5
      @(posedge core_clk) disable iff (rst)
      ovf_hit |=> (stack_trap.pulse && !stack_trap.underflow))
      else $error("no overflow trap");
   a_floor_trap: assert property ( // RULE9
      @(posedge core_clk) disable iff (rst)
      (stack_acc.valid && stack_acc.ea < slc_pkg::STACK_FLOOR) |=> stack_trap.pulse)
      else $error("no floor trap");
   a_sp_aligned: assert property ( // RULE20
      @(posedge core_clk) disable iff (rst)
      !stack_pointer_reg[0])
      else $error("sp misaligned");
   a_trap_pulse: assert property ( // RULE23
      @(posedge core_clk) disable iff (rst)
      (stack_trap.pulse && !ovf_hit && !wrap_hit && !unf_hit) |=> !stack_trap.pulse)
      else $error("trap not pulse");
   a_sat_sticky: assert property ( // RULE15
      @(posedge core_clk) disable iff (rst)
      (status_reg[slc_pkg::BIT_ACC_A_SAT] && !sr_wr) |=> status_reg[slc_pkg::BIT_ACC_A_SAT])
      else $error("saturation lost");
   a_sat_combined: assert property ( // RULE16
      @(posedge core_clk) disable iff (rst)
      status_reg[slc_pkg::BIT_COMB_SAT]
      == (status_reg[slc_pkg::BIT_ACC_A_SAT] | status_reg[slc_pkg::BIT_ACC_B_SAT]))
      else $error("combined sat mismatch");
   a_loop_ro: assert property ( // RULE12
      @(posedge core_clk) disable iff (rst)
      status_reg[slc_pkg::BIT_LOOP_ACT] == $past(eng_flags.loop_active))
      else $error("loop flag wrong");
   a_prio_locked: assert property ( // RULE21
      @(posedge core_clk) disable iff (rst)
      nesting_disable |=> (status_reg[7:5] == $past(status_reg[7:5])))
      else $error("priority changed");
   a_irq_block: assert property ( // RULE22
      @(posedge core_clk) disable iff (rst)
      priority_level_top |=> user_irq_block)
      else $error("irq not blocked");
   a_wrap_trap: assert property ( // RULE7
      @(posedge core_clk) disable iff (rst)
      wrap_hit |=> (stack_trap.pulse && !stack_trap.underflow))
      else $error("no wrap trap");
   a_ovf_ro: assert property ( // RULE14
      @(posedge core_clk) disable iff (rst)
      !$past(rst) |-> (status_reg[slc_pkg::BIT_ACC_A_OVF] == $past(eng_flags.acc_a_ovf)))
      else $error("overflow flag wrong");
   a_comb_ovf: assert property ( // RULE14
      @(posedge core_clk) disable iff (rst)
      status_reg[slc_pkg::BIT_COMB_OVF]
      == (status_reg[slc_pkg::BIT_ACC_A_OVF] | status_reg[slc_pkg::BIT_ACC_B_OVF]))
      else $error("combined overflow mismatch");
   a_repeat_ro: assert property ( // RULE13
      @(posedge core_clk) disable iff (rst)
      !$past(rst) |-> (status_reg[slc_pkg::BIT_REPEAT_ACT] == $past(eng_flags.repeat_active)))
      else $error("repeat flag wrong");
   a_sat_no_set: assert property ( // RULE15
      @(posedge core_clk) disable iff (rst)
      (!status_reg[slc_pkg::BIT_ACC_A_SAT] && !eng_flags.acc_a_sat)
      |=> !status_reg[slc_pkg::BIT_ACC_A_SAT])
      else $error("saturation set by software");
   a_sab_clear: assert property ( // RULE16
      @(posedge core_clk) disable iff (rst)
      (sr_wr && high_wr && !wdata16[slc_pkg::BIT_COMB_SAT] && !eng_flags.acc_a_sat
      && !eng_flags.acc_b_sat) |=> (status_reg[13:12] == 2'h0))
      else $error("combined clear kept a flag");
   a_exc_word: assert property ( // RULE11
      @(posedge core_clk) disable iff (rst)
      !$past(rst) |-> (exc_stack_word == {$past(pc_top_byte), status_reg[7:0]}))
      else $error("stacked word wrong");
   a_prio_level: assert property ( // RULE19
      @(posedge core_clk) disable iff (rst)
      !$past(rst) |-> (cpu_priority == {$past(priority_level_top), status_reg[7:5]}))
      else $error("priority level wrong");
   a_dc_write: assert property ( // RULE17
      @(posedge core_clk) disable iff (rst)
      (alu_wr && !sr_wr) |=> (status_reg[slc_pkg::BIT_DIGIT_CARRY] == $past(alu_flags[4])))
      else $error("digit carry not written");
   a_under_cause: assert property ( // RULE23
      @(posedge core_clk) disable iff (rst)
      (unf_hit && !ovf_hit && !wrap_hit) |=> (stack_trap.pulse && stack_trap.underflow))
      else $error("underflow cause wrong");
   a_idle_quiet: assert property ( // RULE23
      @(posedge core_clk) disable iff (rst)
      !stack_acc.valid |=> !stack_trap.pulse)
      else $error("trap without access");
   a_disabled_quiet: assert property ( // RULE2
      @(posedge core_clk) disable iff (rst)
      (!check_en_reg && stack_acc.valid && stack_acc.ea >= slc_pkg::STACK_FLOOR)
      |=> !stack_trap.pulse)
      else $error("trap while checking off");
endmodule

/* File: pkg/slc_pkg.sv */
// Purpose: Shared constants and types for the stack check and status word block
// Assumes: 32-bit APB, one register per aligned word
// Notes: Status word bit positions follow the register layout
package slc_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_STACK_LIMIT = 8'h00;
   localparam logic [7:0] OFS_STATUS_WORD = 8'h04;
   localparam logic [7:0] OFS_STACK_PTR = 8'h08;
   localparam logic [7:0] OFS_CONTROL = 8'h0C;
   localparam logic [7:0] OFS_TRAP_INFO = 8'h10;
   // ------------------------------------------------------------
   // Reset values and limits
   // ------------------------------------------------------------
   localparam logic [15:0] STACK_PTR_RESET = 16'h0800;
   localparam logic [15:0] STACK_FLOOR = 16'h0800;
   localparam logic [15:0] STACK_LIMIT_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] STACK_STEP = 16'h0002;
   // ------------------------------------------------------------
   // Status word bit positions
   // ------------------------------------------------------------
   localparam int BIT_ACC_A_OVF = 15;
   localparam int BIT_ACC_B_OVF = 14;
   localparam int BIT_ACC_A_SAT = 13;
   localparam int BIT_ACC_B_SAT = 12;
   localparam int BIT_COMB_OVF = 11;
   localparam int BIT_COMB_SAT = 10;
   localparam int BIT_LOOP_ACT = 9;
   localparam int BIT_DIGIT_CARRY = 8;
   localparam int BIT_PRIO_HI = 7;
   localparam int BIT_PRIO_LO = 5;
   localparam int BIT_REPEAT_ACT = 4;
   // Bits that software may write freely
   localparam logic [15:0] SW_WRITE_MASK = 16'h01EF;
   localparam logic [15:0] PRIO_MASK = 16'h00E0;
   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;    // Address being formed from stack pointer
      logic is_push;  // Push style access (post increment)
      logic is_pop;   // Pop style access (pre decrement)
      logic [15:0] ea; // Effective address
   } slc_stack_access_t;
   typedef struct packed {
      logic acc_a_ovf;
      logic acc_b_ovf;
      logic acc_a_sat;
      logic acc_b_sat;
      logic loop_active;
      logic repeat_active;
   } slc_engine_flags_t;
   typedef struct packed {
      logic pulse;     // One cycle trap request
      logic underflow; // Cause: 1 underflow, 0 overflow or wrap
   } slc_trap_t;
endpackage

/* File: dv/slc_core_model.sv */
// Purpose: Core side model making stack accesses, engine flags and flag writes
// Assumes: Everything changes by non-blocking assignment just after a rising edge
// Notes: The bench calls the tasks; one request per call
module slc_core_model (
   input wire logic core_clk, // Core clock
   output slc_pkg::slc_stack_access_t stack_acc, // Stack pointer access
   output slc_pkg::slc_engine_flags_t eng_flags, // Engine and loop flags
   output logic alu_wr, // Flag write strobe
   output logic [4:0] alu_flags // Digit carry, N, OV, Z, C
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      stack_acc = '0;
      eng_flags = '0;
      alu_wr = 1'h0;
      alu_flags = 5'h00;
   end
   // idle lead cycle
   // Leading idle edge keeps an access clear of a fresh limit write
   task automatic access(input logic push, input logic [15:0] ea);
      @(posedge core_clk);
      @(posedge core_clk);
      stack_acc <= {1'h1, push, ~push, ea};
      @(posedge core_clk);
      stack_acc <= {3'h0, ~ea};
   endtask
   task automatic set_eng(input slc_pkg::slc_engine_flags_t f);
      @(posedge core_clk);
      eng_flags <= f;
   endtask
   task automatic alu(input logic [4:0] f);
      @(posedge core_clk);
      alu_wr <= 1'h1;
      alu_flags <= f;
      @(posedge core_clk);
      alu_wr <= 1'h0;
      alu_flags <= ~f;
   endtask
endmodule

/* File: dv/slc_stack_status_test.sv */
// Purpose: Self-checking bench for the stack check and status word block
// Assumes: Zero wait APB slave, registered outputs one cycle behind inputs
// Notes: Stack pointer load is driven alone; its priority is not exercised
module slc_stack_status_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, top, nd, blk, err, en;
   logic ovf, uf, alu_wr, sat_a, sat_b, sld;
   logic [7:0] paddr, pc;
   logic [31:0] pwdata, prdata, rd, v;
   logic [3:0] pstrb, prio;
   logic [4:0] alu_f;
   logic [15:0] sp, esw, lim, msp, sw, slv, x;
   slc_pkg::slc_stack_access_t acc;
   slc_pkg::slc_engine_flags_t eng;
   slc_pkg::slc_trap_t trap;
   int error_cnt, checked, seed;
   slc_stack_status i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stack_acc(acc), .sp_load(sld),
      .sp_load_val(slv), .eng_flags(eng), .alu_wr(alu_wr), .alu_flags(alu_f),
      .priority_level_top(top), .nesting_disable(nd), .pc_top_byte(pc), .stack_trap(trap),
      .cpu_priority(prio), .user_irq_block(blk), .exc_stack_word(esw),
      .stack_pointer_reg(sp));
   slc_core_model i_core (.core_clk(core_clk), .stack_acc(acc), .eng_flags(eng),
      .alu_wr(alu_wr), .alu_flags(alu_f));
   // ------------------------------------------------------------
   // Clock, watchdog, closing
   // ------------------------------------------------------------
   initial
   begin
      core_clk = 1'h0;
      forever #20 core_clk = ~core_clk;
   end
   // Roughly 37 times the expected run of about 200 cycles
   initial
   begin
      #300000;
      error_cnt++;
      report_and_stop();
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Bus cycles, model and comparison
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'h1;
      do
         @(posedge core_clk);
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0, 4'h0);
      chk("read data", e, rd);
      chk("slave error", 32'h0, {31'h0, err});
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
      logic [15:0] m;
      apb(1'h1, a, {16'h0000, d}, {2'h0, s});
      m = slc_pkg::SW_WRITE_MASK & ~(nd ? slc_pkg::PRIO_MASK : 16'h0000);
      if (a == slc_pkg::OFS_STACK_LIMIT)
      begin
         lim = (lim & ~{{8{s[1]}}, {8{s[0]}}}) | (d & {{8{s[1]}}, {7{s[0]}}, 1'h0});
         en = en | (s == 2'h3);
      end
      if (a == slc_pkg::OFS_STACK_PTR && s == 2'h3)
         msp = d & 16'hFFFE;
      if (a == slc_pkg::OFS_STATUS_WORD)
      begin
         sw = (sw & ~m) | (d & m);
         sat_a = sat_a & d[13] & d[10];
         sat_b = sat_b & d[12] & d[10];
      end
   endtask
   function automatic logic [15:0] esr();
      esr = sw;
      esr[15] = eng.acc_a_ovf;
      esr[14] = eng.acc_b_ovf;
      esr[13] = sat_a;
      esr[12] = sat_b;
      esr[11] = eng.acc_a_ovf | eng.acc_b_ovf;
      esr[10] = sat_a | sat_b;
      esr[9] = eng.loop_active;
      esr[4] = eng.repeat_active;
   endfunction
   task automatic stk(input logic push, input logic [15:0] ea);
      ovf = en && push && (ea > lim || {1'h0, ea} + 17'h00002 > 17'h0FFFF);
      uf = ea < 16'h0800;
      i_core.access(push, ea);
      msp = push ? msp + 16'h0002 : msp - 16'h0002;
      #1;
      chk("trap", {30'h0, ovf | uf, uf & ~ovf}, {30'h0, trap});
      @(posedge core_clk);
      #1;
      chk("trap end", 32'h0, {30'h0, trap});
      chk("stack pointer", {16'h0, msp}, {16'h0, sp});
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      seed = 8;
      rst = 1'h1;
      {psel, penable, pwrite, top, nd, en, sat_a, sat_b, sld} = 9'h000;
      paddr = 8'h00;
      pc = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      {lim, sw, slv} = 48'h0;
      msp = 16'h0800;
      repeat (6) @(posedge core_clk);
      rst <= 1'h0;
      rdchk(slc_pkg::OFS_STACK_LIMIT, 32'h0);
      rdchk(slc_pkg::OFS_STATUS_WORD, 32'h0);
      rdchk(slc_pkg::OFS_STACK_PTR, 32'h0800);
      rdchk(slc_pkg::OFS_CONTROL, 32'h0);
      apb(1'h0, 8'h14, 32'h0, 4'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      $display("test reset done");
      wr(slc_pkg::OFS_STACK_PTR, 16'h1235, 2'h3);
      rdchk(slc_pkg::OFS_STACK_PTR, {16'h0, msp});
      v = $random(seed);
      @(posedge core_clk);
      sld <= 1'h1;
      slv <= v[15:0];
      @(posedge core_clk);
      sld <= 1'h0;
      msp = slv & 16'hFFFE;
      rdchk(slc_pkg::OFS_STACK_PTR, {16'h0, msp});
      stk(1'h1, 16'h0900);
      stk(1'h0, 16'h07FE);
      wr(slc_pkg::OFS_STACK_LIMIT, 16'h1FFF, 2'h1);
      rdchk(slc_pkg::OFS_CONTROL, 32'h0);
      stk(1'h1, 16'h0900);
      wr(slc_pkg::OFS_STACK_LIMIT, 16'h1FFF, 2'h3);
      rdchk(slc_pkg::OFS_STACK_LIMIT, {16'h0, lim});
      rdchk(slc_pkg::OFS_CONTROL, 32'h1);
      stk(1'h1, 16'h1FFE);
      stk(1'h1, 16'h2000);
      stk(1'h0, 16'h2000);
      wr(slc_pkg::OFS_STACK_LIMIT, 16'hFFFE, 2'h3);
      stk(1'h1, 16'hFFFE);
      stk(1'h1, 16'hFFFC);
      wr(slc_pkg::OFS_STACK_LIMIT, 16'h0000, 2'h2);
      rdchk(slc_pkg::OFS_CONTROL, 32'h1);
      stk(1'h1, 16'h0900);
      $display("test stack check done");
      for (int i = 0; i < 8; i++)
      begin
         v = $random(seed);
         nd <= v[16];
         top <= v[17];
         pc <= v[25:18];
         i_core.set_eng({v[31:30], 2'h0, v[29:28]});
         wr(slc_pkg::OFS_STATUS_WORD, v[15:0], 2'h3);
         rdchk(slc_pkg::OFS_STATUS_WORD, {16'h0, esr()});
         chk("priority", {28'h0, top, sw[7:5]}, {28'h0, prio});
         chk("irq block", {31'h0, top}, {31'h0, blk});
         x = esr();
         chk("stacked word", {16'h0, pc, x[7:0]}, {16'h0, esw});
      end
      rdchk(slc_pkg::OFS_TRAP_INFO, {28'h0, top, sw[7:5]});
      $display("test status access done");
      i_core.set_eng(6'h0C);
      i_core.set_eng(6'h00);
      {sat_a, sat_b} = 2'h3;
      rdchk(slc_pkg::OFS_STATUS_WORD, {16'h0, esr()});
      wr(slc_pkg::OFS_STATUS_WORD, 16'hFFFF, 2'h3);
      rdchk(slc_pkg::OFS_STATUS_WORD, {16'h0, esr()});
      wr(slc_pkg::OFS_STATUS_WORD, 16'hFBFF, 2'h3);
      rdchk(slc_pkg::OFS_STATUS_WORD, {16'h0, esr()});
      i_core.set_eng(6'h08);
      i_core.set_eng(6'h00);
      sat_a = 1'h1;
      wr(slc_pkg::OFS_STATUS_WORD, 16'hDFFF, 2'h3);
      rdchk(slc_pkg::OFS_STATUS_WORD, {16'h0, esr()});
      i_core.alu(5'h15);
      sw = (sw & 16'hFEF0) | 16'h0105;
      rdchk(slc_pkg::OFS_STATUS_WORD, {16'h0, esr()});
      $display("test sticky and flags done");
      rst <= 1'h1;
      repeat (3) @(posedge core_clk);
      rst <= 1'h0;
      {lim, sw, en, sat_a, sat_b} = 35'h0;
      msp = slc_pkg::STACK_PTR_RESET;
      rdchk(slc_pkg::OFS_CONTROL, 32'h0);
      rdchk(slc_pkg::OFS_STATUS_WORD, {16'h0, esr()});
      stk(1'h1, 16'h0900);
      $display("test second reset done");
      report_and_stop();
   end
endmodule
